// *** core/pps_period_gen.sv ***
// Purpose: Repetition period generator for the PROM pulse sequencer
// Assumes: Enables are already synchronised to clk_i
// Notes:   Emits a one-cycle start pulse at enable and every period after
`timescale 1ns/10ps
`default_nettype none
module pps_period_gen
  import pps_pkg::*;
#(
  parameter int TICKS_PER_US = CYC_PER_US // Clock cycles per microsecond
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic fast_en_i,
  input wire logic slow_en_i,
  output logic start_o
);

  // ==========================================================================
  // Period counter
  // ==========================================================================
  logic [CNT_W-1:0] cnt_ff;   // Cycles since last start
  logic active;               // Some enable is held
  logic [CNT_W-1:0] limit;    // Last count of the current period

  // Period lengths in clock cycles at the chosen tick rate
  localparam int FAST_N = PERIOD_FAST_US * TICKS_PER_US;
  localparam int SLOW_N = PERIOD_SLOW_US * TICKS_PER_US;

  assign active = fast_en_i | slow_en_i;
  // Fast rate wins when both enables are held
  assign limit = fast_en_i ? CNT_W'(FAST_N - 1)
                           : CNT_W'(SLOW_N - 1);

  // Restart from zero whenever the enables drop
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_ff <= '0;
      start_o <= 1'b0;
    end
    else if (!active)
    begin
      cnt_ff <= '0;
      start_o <= 1'b0;
    end
    else
    begin
      // Fire at count zero, then wrap at the period
      start_o <= (cnt_ff == '0);
      cnt_ff <= (cnt_ff >= limit) ? '0 : cnt_ff + 1'b1;
    end
  end

endmodule // pps_period_gen
`default_nettype wire

// *** core/pps_pkg.sv ***
// Purpose: Shared constants and carrier types for the PROM pulse sequencer
// Assumes: 100 MHz clock, 10 ns period
// Notes:   All times are held in their own unit and turned into cycle counts
package pps_pkg;

  // ==========================================================================
  // Clock
  // ==========================================================================
  localparam int CLK_PERIOD_PS = 10000;  // Clock period in picoseconds

  // ==========================================================================
  // Times as printed, in microseconds
  // ==========================================================================
  localparam int PERIOD_FAST_US = 15000;  // Repetition period, 20% duty
  localparam int PERIOD_SLOW_US = 150000; // Repetition period, 2% duty
  localparam int CYCLE_US = 3250;         // Program cycle length
  localparam int ADDR_INV_US = 60;        // Address complement window
  localparam int STROBE_DLY_US = 155;     // Delay before strobe
  localparam int STROBE_LEN_US = 3000;    // Strobe pulse length

  // ==========================================================================
  // Derived cycle counts (1 us = 100 cycles, exact at this rate)
  // ==========================================================================
  localparam int CYC_PER_US = 1000000 / CLK_PERIOD_PS;
  localparam int PERIOD_FAST_CYC = PERIOD_FAST_US * CYC_PER_US;
  localparam int PERIOD_SLOW_CYC = PERIOD_SLOW_US * CYC_PER_US;
  localparam int CYCLE_CYC = CYCLE_US * CYC_PER_US;
  localparam int ADDR_INV_CYC = ADDR_INV_US * CYC_PER_US;
  localparam int STROBE_ON_CYC = STROBE_DLY_US * CYC_PER_US;
  localparam int STROBE_OFF_CYC = (STROBE_DLY_US + STROBE_LEN_US) * CYC_PER_US;

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int CNT_W = 24;              // Width of the timing counters
  localparam int DATA_W = 8;              // PROM address and data width
  localparam logic [7:0] BYTE_RST = 8'h00; // Reset value of address, data and readback outputs

  // Sequencer states, Gray coded along the usual path except PPS_WAIT to PPS_IDLE
  typedef enum logic [1:0]
  {
    PPS_IDLE = 2'b00,
    PPS_INVERT = 2'b01,
    PPS_WAIT = 2'b11,
    PPS_STROBE = 2'b10
  } pps_state_t;

  // Control bundle that reaches the PROM socket drivers
  typedef struct packed
  {
    logic supply_on;       // High-voltage supplies at programming level
    logic data_drive;      // Data drivers enabled
    logic addr_invert;     // Address driven complemented
    logic program_strobe;  // Program strobe active
  } pps_ctl_t;

  localparam pps_ctl_t CTL_IDLE = '{1'b0, 1'b0, 1'b0, 1'b0};

endpackage : pps_pkg

// *** core/pps_sequencer.sv ***
// Purpose: PROM program pulse sequencer, timing and socket drive control
// Assumes: 100 MHz clk_i; enables arrive asynchronously from a host port
// Notes:   Address and data inputs are complemented by the host
//
// Notes on behaviour
// - Held fast enable restarts cycle every 15 ms
// - Fast enable gives 3 ms per 15 ms
// - Slow enable gives 2 percent duty
// - Each start runs one 3.25 ms cycle
// - Start inverts address, drives data, raises supplies
// - Address returns to true form after 60 us
// - Strobe starts at 155 us, lasts 3 ms
// - Strobe inactive after pulse until cycle end
// - At 3.25 ms all outputs return idle
// - Outside cycles, PROM contents reach host
`timescale 1ns/10ps
`default_nettype none
module pps_sequencer
  import pps_pkg::*;
#(
  parameter int TICKS_PER_US = CYC_PER_US // Clock cycles per microsecond
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic fast_en_n_i,
  input wire logic slow_en_n_i,
  input wire logic [DATA_W-1:0] addr_n_i,
  input wire logic [DATA_W-1:0] data_n_i,
  input wire logic [DATA_W-1:0] prom_data_i,
  output logic [DATA_W-1:0] prom_addr_o,
  output logic [DATA_W-1:0] prom_data_o,
  output logic [DATA_W-1:0] prom_data_oe_n_o,
  output logic [DATA_W-1:0] read_data_o,
  output logic supply_on_o,
  output logic program_strobe_o,
  output logic busy_o
);

  // Interval lengths in clock cycles at the chosen tick rate
  localparam int ADDR_INV_N = ADDR_INV_US * TICKS_PER_US;
  localparam int STROBE_ON_N = STROBE_DLY_US * TICKS_PER_US;
  localparam int STROBE_OFF_N =
    (STROBE_DLY_US + STROBE_LEN_US) * TICKS_PER_US;
  localparam int CYCLE_N = CYCLE_US * TICKS_PER_US;
  localparam int PERIOD_FAST_N = PERIOD_FAST_US * TICKS_PER_US;

  // ==========================================================================
  // Enable synchronisers
  // ==========================================================================
  logic [2:0] fast_sync_ff;  // Three-stage chain, fast enable (inverted)
  logic [2:0] slow_sync_ff;  // Three-stage chain, slow enable (inverted)
  logic fast_en_ff;          // Accepted fast enable level
  logic slow_en_ff;          // Accepted slow enable level

  // Shift active-high enables through the chains
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fast_sync_ff <= 3'h0;
      slow_sync_ff <= 3'h0;
    end
    else
    begin
      fast_sync_ff <= {fast_sync_ff[1:0], ~fast_en_n_i};
      slow_sync_ff <= {slow_sync_ff[1:0], ~slow_en_n_i};
    end
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fast_en_ff <= 1'b0;
      slow_en_ff <= 1'b0;
    end
    else
    begin
      if (fast_sync_ff[1] == fast_sync_ff[2])
        fast_en_ff <= fast_sync_ff[2];
      if (slow_sync_ff[1] == slow_sync_ff[2])
        slow_en_ff <= slow_sync_ff[2];
    end
  end

  // ==========================================================================
  // Period generator
  // ==========================================================================
  logic start;  // One-cycle pulse at each period start

  // Fast rate 15 ms, slow rate 150 ms, counted from clk_i
  pps_period_gen
  #(
    .TICKS_PER_US(TICKS_PER_US)
  )
  u_period
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .fast_en_i(fast_en_ff),
    .slow_en_i(slow_en_ff),
    .start_o(start)
  );

  // ==========================================================================
  // Cycle state machine
  // ==========================================================================
  pps_state_t state_ff;      // Sequencer state
  pps_state_t nxt_state;     // Next state
  logic [CNT_W-1:0] tick_ff; // Cycles since cycle start
  logic last_tick;           // Final cycle of the program cycle

  assign last_tick = (tick_ff == CNT_W'(CYCLE_N - 1));

  // Next state from the elapsed count
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      PPS_IDLE:
        if (start)
          nxt_state = PPS_INVERT;
      PPS_INVERT:
        if (tick_ff == CNT_W'(ADDR_INV_N - 1))
          nxt_state = PPS_WAIT;
      PPS_WAIT:
        if (tick_ff == CNT_W'(STROBE_ON_N - 1))
          nxt_state = PPS_STROBE;
        else if (last_tick)
          nxt_state = PPS_IDLE;
      PPS_STROBE:
        if (tick_ff == CNT_W'(STROBE_OFF_N - 1))
          nxt_state = PPS_WAIT;
      default:
        nxt_state = PPS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_ff <= PPS_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Elapsed count, zero in the first cycle of a program cycle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tick_ff <= '0;
    else if (state_ff == PPS_IDLE)
      tick_ff <= '0;
    else
      tick_ff <= tick_ff + 1'b1;
  end

  // ==========================================================================
  // Socket drive
  // ==========================================================================
  pps_ctl_t nxt_ctl; // Control bundle for the next cycle
  pps_ctl_t ctl_ff;  // Registered control bundle

  // Decode the control bundle from the next state
  always_comb
  begin
    nxt_ctl = CTL_IDLE;
    if (nxt_state != PPS_IDLE)
    begin
      nxt_ctl.supply_on = 1'b1;
      nxt_ctl.data_drive = 1'b1;
      nxt_ctl.addr_invert = (nxt_state == PPS_INVERT);
      nxt_ctl.program_strobe = (nxt_state == PPS_STROBE);
    end
  end

  // Registered control; idle again in the cycle after the final tick
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ctl_ff <= CTL_IDLE;
    else
      ctl_ff <= nxt_ctl;
  end

  // Address, data and readback registers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prom_addr_o <= BYTE_RST;
      prom_data_o <= BYTE_RST;
      prom_data_oe_n_o <= 8'hFF;
      read_data_o <= BYTE_RST;
    end
    else
    begin
      // Host gives complemented address; true form undoes it
      prom_addr_o <= nxt_ctl.addr_invert ? addr_n_i : ~addr_n_i;
      prom_data_o <= ~data_n_i;
      prom_data_oe_n_o <= {DATA_W{~nxt_ctl.data_drive}};
      // Readback only while no cycle runs
      if (nxt_ctl == CTL_IDLE && ctl_ff == CTL_IDLE)
        read_data_o <= prom_data_i;
    end
  end

  assign supply_on_o = ctl_ff.supply_on;
  assign program_strobe_o = ctl_ff.program_strobe;
  assign busy_o = ctl_ff.data_drive;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [CNT_W-1:0] sup_age_ff; // Cycles since supply rose, checks only
  logic [CNT_W-1:0] gap_ff; // Cycles since last fast start, 0 = none yet

  // Age of the running cycle, counted from the supply output itself
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sup_age_ff <= '0;
    else if (supply_on_o)
      sup_age_ff <= sup_age_ff + 1'b1;
    else
      sup_age_ff <= '0;
  end

  // Distance between start pulses while the fast enable is held
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      gap_ff <= '0;
    else if (!fast_en_ff)
      gap_ff <= '0;
    else if (start)
      gap_ff <= CNT_W'(1);
    else if (gap_ff != '0)
      gap_ff <= gap_ff + 1'b1;
  end

  sequence s_cycle_start;
    $rose(supply_on_o);
  endsequence

  sequence s_inv_window;
    (prom_addr_o == $past(addr_n_i))[*8];
  endsequence

  sequence s_strobe_due;
    supply_on_o && (sup_age_ff == CNT_W'(STROBE_ON_N));
  endsequence

  inv_start_a: assert property (s_cycle_start |-> ctl_ff.addr_invert)
    else $error("address not inverted at cycle start");
  strobe_dly_a: assert property (
      s_strobe_due |-> $rose(program_strobe_o))
    else $error("strobe not at its start offset");
  cyc_len_a: assert property (
      $fell(supply_on_o) |-> sup_age_ff == CNT_W'(CYCLE_N))
    else $error("cycle length wrong");
  cyc_max_a: assert property (
      supply_on_o |-> sup_age_ff < CNT_W'(CYCLE_N))
    else $error("cycle runs too long");
  inv_end_a: assert property (
      supply_on_o |->
      ctl_ff.addr_invert == (sup_age_ff < CNT_W'(ADDR_INV_N)))
    else $error("inversion window wrong");
  strobe_len_a: assert property (
      supply_on_o |-> program_strobe_o ==
      (sup_age_ff >= CNT_W'(STROBE_ON_N) &&
      sup_age_ff < CNT_W'(STROBE_OFF_N)))
    else $error("strobe window wrong");
  strobe_in_a: assert property (program_strobe_o |-> supply_on_o)
    else $error("strobe outside cycle");
  idle_all_a: assert property ($fell(supply_on_o) |->
      !program_strobe_o && !busy_o && !ctl_ff.addr_invert)
    else $error("outputs not idle at end");
  inv_addr_a: assert property (s_cycle_start |-> ##1 s_inv_window)
    else $error("address not complemented");
  start_rate_a: assert property (
      fast_en_ff && gap_ff == CNT_W'(PERIOD_FAST_N) |-> start)
    else $error("period start missing");
  start_early_a: assert property (
      start && fast_en_ff && gap_ff != '0 |->
      gap_ff == CNT_W'(PERIOD_FAST_N))
    else $error("period start early");
  read_back_a: assert property (
      (!busy_o && !supply_on_o) ##1 !busy_o |->
      read_data_o == $past(prom_data_i))
    else $error("readback not passed");

endmodule // pps_sequencer
`default_nettype wire

// *** tb/pps_prom_model.sv ***
// Purpose: Behavioural PROM sitting in the programming socket
// Assumes: Erased cells read 8'h00
// Notes:   A cell takes the driven byte when a strobe pulse ends
`timescale 1ns/10ps
`default_nettype none
module pps_prom_model
(
  input wire logic clk_i,
  input wire logic supply_on_i,
  input wire logic program_strobe_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic [7:0] data_oe_n_i,
  output logic [7:0] pin_o
);
  logic [7:0] mem [256]; // Cell array
  logic strobe_ff; // Strobe one cycle ago
  // ==========================================================================
  // Cell store
  // ==========================================================================
  initial foreach (mem[i]) mem[i] = 8'h00;
  // Write on the trailing edge of a strobe under raised supply
  always @(posedge clk_i)
  begin
    strobe_ff <= program_strobe_i;
    if (strobe_ff && !program_strobe_i && supply_on_i)
      mem[addr_i] <= data_i;
  end
  // Enabled drivers win per bit, else the addressed cell drives the pin
  always_comb
    for (int b = 0; b < 8; b++)
      pin_o[b] = data_oe_n_i[b] ? mem[addr_i][b] : data_i[b];
endmodule // pps_prom_model
`default_nettype wire

// *** tb/prom_program_pulse_sequencer_tb_top.sv ***
// Purpose: Self-checking bench for the PROM pulse sequencer
// Assumes: Timing scaled to one clock per microsecond, shapes exact
// Notes:   Every socket output is compared on every cycle of a cycle
`timescale 1ns/10ps
`default_nettype none
module prom_program_pulse_sequencer_tb_top
  import pps_pkg::*;
;
  logic clk = 1'b0; // Bench clock
  logic rst_n = 1'b0; // Reset, active low
  logic fast_en_n = 1'b1; // Fast enable, active low
  logic slow_en_n = 1'b1; // Slow enable, active low
  logic [7:0] addr_n = 8'hFF; // Host address, complemented
  logic [7:0] data_n = 8'hFF; // Host data, complemented
  logic [7:0] pin, addr, data, oe_n, rd; // Socket and read lines
  logic sup, strb, busy; // Control outputs
  int n_fail = 0;
  int num_checks = 0;
  // One clock per microsecond keeps the run short
  localparam int TPU = 1;
  localparam int INV_N = ADDR_INV_US * TPU;
  localparam int SON_N = STROBE_DLY_US * TPU;
  localparam int SOFF_N = (STROBE_DLY_US + STROBE_LEN_US) * TPU;
  localparam int CYC_N = CYCLE_US * TPU;
  localparam int PER_N = PERIOD_FAST_US * TPU;

  // 100 MHz clock
  always #5 clk = ~clk;

  pps_sequencer #(.TICKS_PER_US(TPU)) u_dut (.clk_i(clk), .rst_n_i(rst_n),
    .fast_en_n_i(fast_en_n),
    .slow_en_n_i(slow_en_n), .addr_n_i(addr_n), .data_n_i(data_n),
    .prom_data_i(pin), .prom_addr_o(addr), .prom_data_o(data),
    .prom_data_oe_n_o(oe_n), .read_data_o(rd), .supply_on_o(sup),
    .program_strobe_o(strb), .busy_o(busy));

  pps_prom_model u_prom (.clk_i(clk), .supply_on_i(sup),
    .program_strobe_i(strb), .addr_i(addr), .data_i(data),
    .data_oe_n_i(oe_n), .pin_o(pin));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // Compare and count; prints are capped so a slip cannot flood the log
  task automatic chk(string what, logic [39:0] exp, logic [39:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      if (n_fail < 10)
        $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    if (n_fail == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Wait for supply rise, then follow one cycle to its idle cycle
  task automatic run_cycle(input int wmax, input logic [7:0] a_n, d_n,
    input logic [7:0] rd_exp, output int waited);
    logic act;
    logic [34:0] exp;
    waited = 0;
    while (sup !== 1'b1 && waited < wmax)
    begin
      tick();
      waited++;
    end
    for (int k = 0; k <= CYC_N; k++)
    begin
      act = k < CYC_N;
      exp = {act, act, k >= SON_N && k < SOFF_N,
        act ? 8'h00 : 8'hFF, (act && k < INV_N) ? a_n : ~a_n, ~d_n,
        rd_exp};
      chk("socket drive", 40'(exp), 40'({sup, busy, strb, oe_n, addr, data,
        rd}));
      if (act)
        tick();
    end
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    chk("reset outputs", 40'h00FF000000, 40'({sup, busy, strb, oe_n, addr,
      data, rd}));
  endtask

  // Held fast enable: two cycles one period apart, then silence
  task automatic t_fast();
    int w;
    int bad;
    bad = 0;
    addr_n = 8'hA5;
    data_n = 8'h3C;
    fast_en_n = 1'b0;
    run_cycle(100, 8'hA5, 8'h3C, 8'h00, w);
    run_cycle(PER_N, 8'hA5, 8'h3C, 8'hC3, w);
    chk("period gap", 40'(PER_N - CYC_N), 40'(w));
    // Release, then watch one period plus 100 cycles for any supply rise
    fast_en_n = 1'b1;
    for (int i = 0; i < PER_N + 100; i++)
    begin
      if (sup !== 1'b0)
        bad++;
      tick();
    end
    chk("no start after release", 40'd0, 40'(bad));
  endtask

  // Idle read-back follows the address to blank and programmed cells
  task automatic t_read();
    logic [7:0] exp_tab [2] = '{8'h00, 8'hC3};
    logic [7:0] adr_tab [2] = '{8'h00, 8'hA5};
    for (int j = 0; j < 2; j++)
    begin
      addr_n = adr_tab[j];
      for (int i = 0; i < 20 && rd !== exp_tab[j]; i++)
        tick();
      chk("read back", 40'(exp_tab[j]), 40'(rd));
    end
  endtask

  // Slow enable alone runs a cycle of the same shape
  task automatic t_slow();
    int w;
    addr_n = 8'h5A;
    data_n = 8'hF0;
    slow_en_n = 1'b0;
    run_cycle(100, 8'h5A, 8'hF0, 8'h00, w);
    chk("slow start seen", 40'd1, 40'(w < 100));
    slow_en_n = 1'b1;
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    t_reset();
    rst_n = 1'b1;
    tick();
    t_fast();
    t_read();
    t_slow();
    conclude();
  end

  // Whole run needs about 0.4 ms of simulated time
  initial
  begin
    #1000000;
    n_fail++;
    conclude();
  end
endmodule // prom_program_pulse_sequencer_tb_top
`default_nettype wire
